// ---- tb/tb_top.sv ----
// Self-checking bench for the waveform input and fault protection block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
            n_fail++; \
        end \
    end
module tb_top
    import wfp_pkg::*;
;
    logic clk, rstn, ce, sample_clk, spi_csn, spi_sclk, spi_sdi, spi_sdo;
    logic [WFP_SAMPLE_W-1:0] parallel_sample_bus, converter_code;
    logic [WFP_THR_W-1:0] meas [WFP_NUM_MON];
    logic shutdown_pin_i, shutdown_pin_o, shutdown_pin_oe;
    logic shutdown_clear_control, driver_enable, streaming_mode;
    logic host_pull_low;
    int n_fail = 0;
    int tests_run = 0;

    // Board pull-down; the host sink overrides the device's high drive
    assign shutdown_pin_i = host_pull_low ? 1'b0 :
        (shutdown_pin_oe ? shutdown_pin_o : 1'b0);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    wfp_host_model host_u (.clk(clk), .sample_clk(sample_clk),
        .parallel_sample_bus(parallel_sample_bus), .spi_csn(spi_csn),
        .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

    wfp_top dut_u (.clk(clk), .rstn(rstn), .ce(ce), .sample_clk(sample_clk),
        .spi_csn(spi_csn), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo), .parallel_sample_bus(parallel_sample_bus),
        .converter_code(converter_code), .meas_src_current(meas[0]),
        .meas_snk_current(meas[1]), .meas_pos_voltage(meas[2]),
        .meas_neg_voltage(meas[3]), .meas_temperature(meas[4]),
        .shutdown_pin_i(shutdown_pin_i), .shutdown_pin_o(shutdown_pin_o),
        .shutdown_pin_oe(shutdown_pin_oe),
        .shutdown_clear_control(shutdown_clear_control),
        .driver_enable(driver_enable), .streaming_mode(streaming_mode));

    task automatic ticks(input int n);
        repeat (n) @(negedge clk);
    endtask : ticks

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] unused;
        host_u.spi_xfer(1'b0, a, d, unused);
    endtask : wr

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp,
            input string nm);
        logic [7:0] got;
        host_u.spi_xfer(1'b1, a, 8'h00, got);
        `CHK(nm, exp, got)
    endtask : rd_chk

    // Three ways out of shutdown: restart bit, clear pulse, pin sink
    task automatic re_enable(input int how);
        case (how)
            0: begin
                wr(WFP_ADDR_RESTART, 8'h01);
                wr(WFP_ADDR_RESTART, 8'h00);
            end
            1: begin
                shutdown_clear_control = 1'b1;
                ticks(4);
                shutdown_clear_control = 1'b0;
                ticks(10);
            end
            default: begin
                host_pull_low = 1'b1;
                ticks(10);
                host_pull_low = 1'b0;
                ticks(6);
            end
        endcase
        ticks(8);
    endtask : re_enable

    // Live: word at a rise shows at the next fall; else the word holds
    task automatic stream_chk(input logic live);
        logic [WFP_SAMPLE_W-1:0] exp;
        exp = converter_code;
        for (int k = 0; k < 4; k++) begin
            @(posedge sample_clk);
            if (live) begin
                exp = parallel_sample_bus;
            end
            @(negedge sample_clk);
            #1;
            `CHK("converter_code", exp, converter_code)
        end
    endtask : stream_chk

    task automatic results;
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // Some sixty frames of 3.6 us each; 1 ms leaves a wide margin
    initial begin
        #1000000;
        n_fail++;
        results();
    end

    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        shutdown_clear_control = 1'b0;
        host_pull_low = 1'b0;
        for (int i = 0; i < WFP_NUM_MON; i++) meas[i] = 7'h00;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        ticks(6);
        // Reset state: streaming, protection off
        `CHK("streaming_mode", 1'b1, streaming_mode)
        `CHK("driver_enable", 1'b1, driver_enable)
        `CHK("shutdown_pin_oe", 1'b0, shutdown_pin_oe)
        for (int a = 8; a <= 14; a++) rd_chk(7'(a), 8'h00, "reg_rst");
        stream_chk(1'b1);
        // Either mode bit leaves streaming; the word then holds
        for (int b = 0; b < 2; b++) begin
            wr(b ? WFP_ADDR_CTRL2 : WFP_ADDR_CTRL0, 8'h01);
            ticks(4);
            `CHK("mode_off", 1'b0, streaming_mode)
            stream_chk(1'b0);
            wr(b ? WFP_ADDR_CTRL2 : WFP_ADDR_CTRL0, 8'h00);
            ticks(8);
            `CHK("mode_on", 1'b1, streaming_mode)
            stream_chk(1'b1);
        end
        // Unmapped place: write ignored, reads zero
        wr(7'h20, 8'h5a);
        rd_chk(7'h20, 8'h00, "unmapped");
        // Threshold without arm gives no protection
        wr(WFP_ADDR_THR_FIRST, 8'h10);
        meas[0] = 7'h7f;
        ticks(4);
        `CHK("unarmed_drv", 1'b1, driver_enable)
        rd_chk(WFP_ADDR_FLAGS, 8'h00, "unarmed_flag");
        meas[0] = 7'h00;
        // Each monitor: equal is safe, one above trips, then recovery
        for (int i = 0; i < WFP_NUM_MON; i++) begin
            wr(7'(8 + i), 8'h10);
            wr(7'(8 + i), 8'h90);
            rd_chk(7'(8 + i), 8'h90, "thr_arm");
            meas[i] = 7'h10;
            ticks(3);
            `CHK("at_thr", 1'b1, driver_enable)
            meas[i] = 7'h11;
            ticks(2);
            `CHK("trip_drv", 1'b0, driver_enable)
            `CHK("trip_pin", 1'b1, shutdown_pin_o)
            `CHK("trip_oe", 1'b1, shutdown_pin_oe)
            rd_chk(WFP_ADDR_FLAGS, 8'(1 << i), "flag_set");
            meas[i] = 7'h00;
            ticks(3);
            rd_chk(WFP_ADDR_FLAGS, 8'h00, "flag_fall");
            `CHK("stay_off", 1'b0, driver_enable)
            re_enable(i % 3);
            `CHK("reenable", 1'b1, driver_enable)
            `CHK("pin_free", 1'b0, shutdown_pin_oe)
        end
        // Latch enables: upper bits read zero
        wr(WFP_ADDR_LATCH, 8'hff);
        rd_chk(WFP_ADDR_LATCH, 8'h1f, "latch_bits");
        wr(WFP_ADDR_LATCH, 8'h10);
        meas[4] = 7'h7f;
        ticks(3);
        // Restart with the fault still present is refused
        re_enable(0);
        `CHK("refused", 1'b0, driver_enable)
        meas[4] = 7'h00;
        ticks(3);
        rd_chk(WFP_ADDR_FLAGS, 8'h10, "latched");
        wr(WFP_ADDR_FLAGS, 8'h00);
        rd_chk(WFP_ADDR_FLAGS, 8'h10, "w0_keeps");
        wr(WFP_ADDR_FLAGS, 8'h10);
        rd_chk(WFP_ADDR_FLAGS, 8'h00, "w1_clears");
        meas[4] = 7'h7f;
        ticks(3);
        meas[4] = 7'h00;
        ticks(3);
        wr(WFP_ADDR_LATCH, 8'h00);
        rd_chk(WFP_ADDR_FLAGS, 8'h00, "unlatch");
        re_enable(1);
        `CHK("final_on", 1'b1, driver_enable)
        // Clock enable low freezes protection; the trip waits for it
        ce = 1'b0;
        meas[0] = 7'h7f;
        ticks(4);
        `CHK("ce_freeze", 1'b1, driver_enable)
        ce = 1'b1;
        ticks(2);
        `CHK("ce_run", 1'b0, driver_enable)
        meas[0] = 7'h00;
        results();
    end
endmodule : tb_top
`undef CHK
`default_nettype wire

// ---- tb/wfp_host_model.sv ----
// Host model: sample stream source and serial register master
`timescale 1ns/1ps
`default_nettype none
module wfp_host_model
    import wfp_pkg::*;
(
    input wire logic clk,
    output logic sample_clk,
    output logic [WFP_SAMPLE_W-1:0] parallel_sample_bus,
    output logic spi_csn,
    output logic spi_sclk,
    output logic spi_sdi,
    input wire logic spi_sdo
);
    // Floor of full scale over 100 steps, a linear slow edge
    localparam logic [WFP_SAMPLE_W-1:0] STEP_CODES = 14'h00a3;

    // 32 ns sample clock, offset so it never lines up with clk
    initial begin
        sample_clk = 1'b0;
        #7;
        forever #16 sample_clk = ~sample_clk;
    end

    // New word just after each fall, steady across the capturing rise
    initial parallel_sample_bus = 14'h0000;
    always @(negedge sample_clk) begin
        parallel_sample_bus <= parallel_sample_bus + STEP_CODES;
    end

    initial begin
        spi_csn = 1'b1;
        spi_sclk = 1'b0;
        spi_sdi = 1'b0;
    end

    // One whole frame, mode 0; phases of 5 clk keep sclk under 6 MHz
    task automatic spi_xfer(input logic rd, input logic [6:0] addr,
            input logic [7:0] wdata, output logic [7:0] rdata);
        logic [15:0] frame;
        frame = {rd, addr, wdata};
        rdata = 8'h00;
        @(negedge clk);
        spi_csn = 1'b0;
        repeat (5) @(negedge clk);
        for (int i = 15; i >= 0; i--) begin
            spi_sdi = frame[i];
            repeat (5) @(negedge clk);
            // Read bit settled 2.5 clk after the fall, taken before rise
            if (i < 8) begin
                rdata[i] = spi_sdo;
            end
            spi_sclk = 1'b1;
            repeat (5) @(negedge clk);
            spi_sclk = 1'b0;
        end
        repeat (5) @(negedge clk);
        spi_csn = 1'b1;
        // Deselected line must not look like the last data bit
        spi_sdi = ~spi_sdi;
        repeat (6) @(negedge clk);
    endtask : spi_xfer
endmodule : wfp_host_model
`default_nettype wire

// ---- verilog/wfp_pkg.sv ----
// Shared constants and types for the waveform input and fault protection block
package wfp_pkg;

    // Widths
    localparam int WFP_NUM_MON = 5;
    localparam int WFP_THR_W = 7;
    localparam int WFP_REG_W = 8;
    localparam int WFP_ADDR_W = 7;
    localparam int WFP_SAMPLE_W = 14;
    localparam int WFP_SYNC_W = 5;

    // Register addresses on the serial port
    localparam logic [6:0] WFP_ADDR_CTRL0 = 7'h00;
    localparam logic [6:0] WFP_ADDR_CTRL2 = 7'h02;
    localparam logic [6:0] WFP_ADDR_RESTART = 7'h03;
    localparam logic [6:0] WFP_ADDR_THR_FIRST = 7'h08;
    localparam logic [6:0] WFP_ADDR_THR_LAST = 7'h0c;
    localparam logic [6:0] WFP_ADDR_LATCH = 7'h0d;
    localparam logic [6:0] WFP_ADDR_FLAGS = 7'h0e;

    // Field positions
    localparam int WFP_GEN_MODE_BIT = 0;
    localparam int WFP_PAT_MODE_BIT = 0;
    localparam int WFP_RESTART_BIT = 0;
    localparam int WFP_ARM_BIT = 7;
    localparam int WFP_THR_MSB = 6;
    localparam int WFP_CMD_READ_BIT = 7;

    // Monitor order in flag and latch registers
    localparam int WFP_MON_SRC = 0;
    localparam int WFP_MON_SNK = 1;
    localparam int WFP_MON_POS = 2;
    localparam int WFP_MON_NEG = 3;
    localparam int WFP_MON_TEMP = 4;

    // Synchroniser lanes for pins
    localparam int WFP_SYNC_CSN = 0;
    localparam int WFP_SYNC_SCLK = 1;
    localparam int WFP_SYNC_SDI = 2;
    localparam int WFP_SYNC_PIN = 3;
    localparam int WFP_SYNC_CLR = 4;

    // Reset values and bit counter constants
    localparam logic [7:0] WFP_REG_RST = 8'h00;
    localparam logic [4:0] WFP_MON_RST = 5'h00;
    localparam logic [4:0] WFP_SYNC_RST = 5'h01;
    localparam logic [13:0] WFP_SAMPLE_RST = 14'h0000;
    localparam logic [2:0] WFP_CNT_RST = 3'h0;
    localparam logic [2:0] WFP_CNT_LAST = 3'h7;
    localparam logic [2:0] WFP_CNT_ONE = 3'h1;

    // Serial frame phases
    typedef enum logic [1:0] {
        WFP_SPI_IDLE,
        WFP_SPI_CMD,
        WFP_SPI_DATA
    } wfp_spi_type;

endpackage : wfp_pkg

// ---- verilog/wfp_sample_link.sv ----
// Sample clock domain: parallel sample capture and converter update
`timescale 1ns/1ps
`default_nettype none
module wfp_sample_link
    import wfp_pkg::*;
#(
    parameter int SAMPLE_W = WFP_SAMPLE_W
) (
    input wire logic sample_clk,
    input wire logic rstn,
    input wire logic streaming_mode,
    input wire logic [SAMPLE_W-1:0] parallel_sample_bus,
    output logic [SAMPLE_W-1:0] converter_code
);

    typedef struct packed {
        logic stream_s1;
        logic stream_s2;
        logic [SAMPLE_W-1:0] dac_in;
    } wfp_link_state_type;

    wfp_link_state_type st_r;
    wfp_link_state_type st_nxt;

    // Mode level crosses in two stages; samples are on this clock
    always_comb begin
        st_nxt = st_r;
        st_nxt.stream_s1 = streaming_mode;
        st_nxt.stream_s2 = st_r.stream_s1;
        if (st_r.stream_s2) begin
            st_nxt.dac_in = parallel_sample_bus; // RULE4
        end
    end

    always_ff @(posedge sample_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Driver output follows on the falling edge after capture
    always_ff @(negedge sample_clk or negedge rstn) begin
        if (!rstn) begin
            converter_code <= WFP_SAMPLE_RST;
        end else begin
            converter_code <= st_r.dac_in; // RULE4
        end
    end

    // Captured word is the one present at the rising edge
    property capture_p;
        @(posedge sample_clk) disable iff (!rstn)
        st_r.stream_s2 |=> st_r.dac_in == $past(parallel_sample_bus);
    endproperty
    sample_capture_a: assert property (capture_p) // RULE4
        else $error("sample not captured on rising edge");

endmodule : wfp_sample_link
`default_nettype wire

// ---- verilog/wfp_top.sv ----
// Waveform input and five-monitor fault protection engine with serial regs
// What this block and its host do
// RULE1: Streaming mode is active from power-up
// RULE2: Host clears both mode bits for streaming
// RULE3: Host drives 14-bit samples and sample clock
// RULE4: Capture on rising, update on falling edge
// RULE5: Host keeps sample clock at most 100 MHz
// RULE6: Host may split slow edges into steps
// RULE7: Protection disabled at reset until software enables
// RULE8: Five independent monitors, each own threshold
// RULE9: Thresholds in bits 6:0 at 0x08-0x0C
// RULE10: Bit 7 arms monitor; unarmed gives none
// RULE11: Armed monitor over threshold alarms and shuts down
// RULE12: Flag follows armed fault without latching
// RULE13: Writing one clears flag; zero ignored
// RULE14: Shutdown stays after fault and flag clear
// RULE15: Latch enable keeps flag after fault clears
// RULE16: Writing zero to latch bit clears latch
// RULE17: Alarm drives shutdown pin high until re-enable
// RULE18: Restart bit one then zero re-enables
// RULE19: Clear pulse or pin pulled low re-enables
// RULE20: Host writes threshold, then threshold with arm
// RULE21: Shutdown pin high disables the driver
// RULE22: Monitors at bits 0-4, upper bits zero
`timescale 1ns/1ps
`default_nettype none
module wfp_top
    import wfp_pkg::*;
#(
    parameter int NUM_MON = WFP_NUM_MON,
    parameter int SAMPLE_W = WFP_SAMPLE_W
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic sample_clk,
    input wire logic spi_csn,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    output logic spi_sdo,
    input wire logic [SAMPLE_W-1:0] parallel_sample_bus,
    output logic [SAMPLE_W-1:0] converter_code,
    input wire logic [WFP_THR_W-1:0] meas_src_current,
    input wire logic [WFP_THR_W-1:0] meas_snk_current,
    input wire logic [WFP_THR_W-1:0] meas_pos_voltage,
    input wire logic [WFP_THR_W-1:0] meas_neg_voltage,
    input wire logic [WFP_THR_W-1:0] meas_temperature,
    input wire logic shutdown_pin_i,
    output logic shutdown_pin_o,
    output logic shutdown_pin_oe,
    input wire logic shutdown_clear_control,
    output logic driver_enable,
    output logic streaming_mode
);

    typedef struct packed {
        logic [WFP_SYNC_W-1:0] sync1;
        logic [WFP_SYNC_W-1:0] sync2;
        logic [WFP_SYNC_W-1:0] prev2;
        wfp_spi_type phase;
        logic [2:0] bit_cnt;
        logic [WFP_REG_W-1:0] shift;
        logic [WFP_REG_W-1:0] cmd;
        logic [WFP_REG_W-1:0] sdo_shift;
        logic sdo;
        logic gen_mode;
        logic pat_mode;
        logic restart;
        logic [WFP_NUM_MON-1:0][WFP_REG_W-1:0] thr;
        logic [WFP_NUM_MON-1:0] latch_en;
        logic [WFP_NUM_MON-1:0] flags;
        logic shutdown;
        logic drv_en;
        logic streaming;
    } wfp_top_state_type;

    wfp_top_state_type st_r;
    wfp_top_state_type st_nxt;

    logic [WFP_NUM_MON-1:0][WFP_THR_W-1:0] meas;
    logic [WFP_NUM_MON-1:0] alarm_now;
    logic [WFP_NUM_MON-1:0] arm_vec;
    logic any_alarm;
    logic cs_fall;
    logic sclk_rise;
    logic sclk_fall;
    logic wr_commit;
    logic [WFP_REG_W-1:0] wr_data;
    logic [WFP_ADDR_W-1:0] wr_addr;
    logic flag_wr;
    logic restart_fall;
    logic clr_fall;
    logic pin_fall;
    logic reenable;

    // True when the address selects one of the monitor registers
    function automatic logic is_thr(input logic [WFP_ADDR_W-1:0] addr);
        is_thr = (addr >= WFP_ADDR_THR_FIRST) && (addr <= WFP_ADDR_THR_LAST);
    endfunction : is_thr

    // Monitor index from a monitor register address
    function automatic logic [2:0] thr_idx(input logic [WFP_ADDR_W-1:0] addr);
        logic [WFP_ADDR_W-1:0] diff;
        diff = addr - WFP_ADDR_THR_FIRST;
        thr_idx = diff[2:0];
    endfunction : thr_idx

    // Read mux; unmapped addresses and unused bits read zero
    function automatic logic [WFP_REG_W-1:0] read_data(
        input logic [WFP_ADDR_W-1:0] addr,
        input wfp_top_state_type s
    );
        read_data = WFP_REG_RST;
        if (addr == WFP_ADDR_CTRL0) begin
            read_data[WFP_GEN_MODE_BIT] = s.gen_mode;
        end else if (addr == WFP_ADDR_CTRL2) begin
            read_data[WFP_PAT_MODE_BIT] = s.pat_mode;
        end else if (addr == WFP_ADDR_RESTART) begin
            read_data[WFP_RESTART_BIT] = s.restart;
        end else if (is_thr(addr)) begin
            read_data = s.thr[thr_idx(addr)]; // RULE9
        end else if (addr == WFP_ADDR_LATCH) begin
            read_data[WFP_NUM_MON-1:0] = s.latch_en; // RULE22
        end else if (addr == WFP_ADDR_FLAGS) begin
            read_data[WFP_NUM_MON-1:0] = s.flags; // RULE22
        end
    endfunction : read_data

    // Monitor order fixes the bit of each flag and latch enable
    assign meas[WFP_MON_SRC] = meas_src_current; // RULE22
    assign meas[WFP_MON_SNK] = meas_snk_current;
    assign meas[WFP_MON_POS] = meas_pos_voltage;
    assign meas[WFP_MON_NEG] = meas_neg_voltage;
    assign meas[WFP_MON_TEMP] = meas_temperature;

    // One comparator per monitor, gated by its own arm bit
    genvar g;
    generate
        for (g = 0; g < WFP_NUM_MON; g++) begin : g_mon
            assign arm_vec[g] = st_r.thr[g][WFP_ARM_BIT]; // RULE10
            assign alarm_now[g] = arm_vec[g] &&
                (meas[g] > st_r.thr[g][WFP_THR_MSB:0]); // RULE8 RULE11
        end
    endgenerate
    assign any_alarm = |alarm_now;

    // Serial slave, re-enable sources and protection state
    always_comb begin
        st_nxt = st_r;
        wr_commit = 1'b0;
        wr_data = {st_r.shift[WFP_REG_W-2:0], st_r.sync2[WFP_SYNC_SDI]};
        wr_addr = st_r.cmd[WFP_ADDR_W-1:0];
        // Pins pass two stages; the edge detectors read only stage two
        st_nxt.sync1 = {shutdown_clear_control, shutdown_pin_i,
            spi_sdi, spi_sclk, spi_csn};
        st_nxt.sync2 = st_r.sync1;
        st_nxt.prev2 = st_r.sync2;
        cs_fall = st_r.prev2[WFP_SYNC_CSN] && !st_r.sync2[WFP_SYNC_CSN];
        sclk_rise = st_r.sync2[WFP_SYNC_SCLK] && !st_r.prev2[WFP_SYNC_SCLK];
        sclk_fall = !st_r.sync2[WFP_SYNC_SCLK] && st_r.prev2[WFP_SYNC_SCLK];
        clr_fall = st_r.prev2[WFP_SYNC_CLR] && !st_r.sync2[WFP_SYNC_CLR];
        pin_fall = st_r.prev2[WFP_SYNC_PIN] && !st_r.sync2[WFP_SYNC_PIN];

        // Frame: 8-bit command (read flag, address), then 8 data bits
        if (st_r.sync2[WFP_SYNC_CSN]) begin
            st_nxt.phase = WFP_SPI_IDLE;
            st_nxt.sdo = 1'b0;
        end else begin
            case (st_r.phase)
                WFP_SPI_IDLE: begin
                    if (cs_fall) begin
                        st_nxt.phase = WFP_SPI_CMD;
                        st_nxt.bit_cnt = WFP_CNT_RST;
                    end
                end
                WFP_SPI_CMD: begin
                    if (sclk_rise) begin
                        st_nxt.shift = wr_data;
                        st_nxt.bit_cnt = st_r.bit_cnt + WFP_CNT_ONE;
                        if (st_r.bit_cnt == WFP_CNT_LAST) begin
                            st_nxt.cmd = wr_data;
                            st_nxt.phase = WFP_SPI_DATA;
                            st_nxt.sdo_shift = wr_data[WFP_CMD_READ_BIT] ?
                                read_data(wr_data[WFP_ADDR_W-1:0], st_r) :
                                WFP_REG_RST;
                        end
                    end
                end
                WFP_SPI_DATA: begin
                    // Read data changes on falling edges, MSB first
                    if (sclk_fall) begin
                        st_nxt.sdo = st_r.sdo_shift[WFP_REG_W-1];
                        st_nxt.sdo_shift = {st_r.sdo_shift[WFP_REG_W-2:0],
                            1'b0};
                    end
                    if (sclk_rise) begin
                        st_nxt.shift = wr_data;
                        st_nxt.bit_cnt = st_r.bit_cnt + WFP_CNT_ONE;
                        if (st_r.bit_cnt == WFP_CNT_LAST) begin
                            wr_commit = !st_r.cmd[WFP_CMD_READ_BIT];
                            st_nxt.phase = WFP_SPI_IDLE;
                        end
                    end
                end
                default: begin
                    st_nxt.phase = WFP_SPI_IDLE;
                end
            endcase
        end

        // Register writes at the end of a write frame
        flag_wr = wr_commit && (wr_addr == WFP_ADDR_FLAGS);
        restart_fall = wr_commit && (wr_addr == WFP_ADDR_RESTART) &&
            st_r.restart && !wr_data[WFP_RESTART_BIT]; // RULE18
        if (wr_commit) begin
            if (wr_addr == WFP_ADDR_CTRL0) begin
                st_nxt.gen_mode = wr_data[WFP_GEN_MODE_BIT];
            end else if (wr_addr == WFP_ADDR_CTRL2) begin
                st_nxt.pat_mode = wr_data[WFP_PAT_MODE_BIT];
            end else if (wr_addr == WFP_ADDR_RESTART) begin
                st_nxt.restart = wr_data[WFP_RESTART_BIT];
            end else if (is_thr(wr_addr)) begin
                st_nxt.thr[thr_idx(wr_addr)] = wr_data; // RULE9 RULE10
            end else if (wr_addr == WFP_ADDR_LATCH) begin
                st_nxt.latch_en = wr_data[WFP_NUM_MON-1:0]; // RULE16
            end
        end

        // Live armed fault sets; latch holds; a one clears, set wins
        st_nxt.flags = alarm_now | (st_r.flags & st_r.latch_en &
            ~(flag_wr ? wr_data[WFP_NUM_MON-1:0] : WFP_MON_RST)); // RULE12 RULE13 RULE15

        // Any re-enable source; an armed alarm still present wins
        reenable = restart_fall || clr_fall || pin_fall; // RULE18 RULE19
        st_nxt.shutdown = any_alarm ||
            (st_r.shutdown && !reenable); // RULE11 RULE14 RULE17

        // Pin high from either side keeps the driver off
        st_nxt.drv_en = !st_nxt.shutdown &&
            !st_r.sync2[WFP_SYNC_PIN]; // RULE21
        st_nxt.streaming = !st_nxt.gen_mode && !st_nxt.pat_mode; // RULE1
    end

    // Clock enable freezes the whole control domain
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0; // RULE7
            st_r.sync1 <= WFP_SYNC_RST;
            st_r.sync2 <= WFP_SYNC_RST;
            st_r.prev2 <= WFP_SYNC_RST;
            st_r.phase <= WFP_SPI_IDLE;
            st_r.streaming <= 1'b1; // RULE1
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state
    assign spi_sdo = st_r.sdo;
    assign shutdown_pin_o = st_r.shutdown; // RULE17
    assign shutdown_pin_oe = st_r.shutdown;
    assign driver_enable = st_r.drv_en;
    assign streaming_mode = st_r.streaming;

    // Sample path on the host's sample clock
    wfp_sample_link #(
        .SAMPLE_W(SAMPLE_W)
    ) u_link (
        .sample_clk(sample_clk),
        .rstn(rstn),
        .streaming_mode(st_r.streaming),
        .parallel_sample_bus(parallel_sample_bus),
        .converter_code(converter_code)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    mode_select_a: assert property ( // RULE1
        ce && !st_r.gen_mode && !st_r.pat_mode && !wr_commit
            |=> streaming_mode ##1 1'b1)
        else $error("streaming mode not selected with mode bits clear");

    unarmed_quiet_a: assert property ( // RULE10
        ce && !st_r.shutdown && (arm_vec == WFP_MON_RST)
            |=> !st_r.shutdown && (st_r.flags & ~$past(st_r.latch_en)) == 0)
        else $error("unarmed monitors caused shutdown or flag");

    trip_off_a: assert property ( // RULE11
        ce && any_alarm |=> shutdown_pin_oe && !driver_enable)
        else $error("armed alarm did not shut the driver down");

    flag_follow_a: assert property ( // RULE12
        ce && (st_r.latch_en == WFP_MON_RST)
            |=> st_r.flags == $past(alarm_now))
        else $error("unlatched flag does not follow fault");

    flag_clear_a: assert property ( // RULE13
        ce && flag_wr
            |=> (st_r.flags & $past(wr_data[WFP_NUM_MON-1:0]) &
                ~$past(alarm_now)) == 0)
        else $error("write one did not clear flag");

    shut_hold_a: assert property ( // RULE14
        ce && st_r.shutdown && !reenable |=> st_r.shutdown)
        else $error("shutdown released without re-enable");

    latch_keep_a: assert property ( // RULE15
        ce && !flag_wr
            |=> (st_r.flags & $past(st_r.flags & st_r.latch_en)) ==
                $past(st_r.flags & st_r.latch_en))
        else $error("latched flag lost without clear");

    pin_flag_a: assert property ( // RULE17
        ce && any_alarm ##1 (ce && !reenable)[*2] |=> shutdown_pin_o)
        else $error("shutdown pin not held high after alarm");

    restart_bit_a: assert property ( // RULE18
        ce && restart_fall && !any_alarm |=> !st_r.shutdown)
        else $error("restart bit did not leave shutdown");

    alt_restart_a: assert property ( // RULE19
        ce && (clr_fall || pin_fall) && !any_alarm |=> !shutdown_pin_oe)
        else $error("clear pulse or pin pull did not re-enable");

    pin_disable_a: assert property ( // RULE21
        ce && st_r.sync2[WFP_SYNC_PIN] |=> !driver_enable)
        else $error("driver enabled while shutdown pin high");

endmodule : wfp_top
`default_nettype wire
